//--- hdl/bsx_exec.sv
// Contract
// - Instructions are single 14-bit words
// - d=0 writes accumulator, d=1 writes register
// - File address spans 0x00 to 0x7F
// - Three-bit field selects bit 0..7
// - Literal is eight or eleven bits
// - Don't-care bits never affect execution
// - One cycle; skip adds a NOP cycle
// - Instruction cycle is four oscillator periods
// - Bit clear zeroes bit, flags unchanged
// - Bit set forces bit, flags unchanged
// - Test-skip-if-clear discards next when zero
// - Literal minus accumulator into accumulator, flags
// - Register minus accumulator per destination, flags
// - Carry set when no borrow
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bsx_map.svh"
module bsx_exec (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // *****************************************************************
   // State
   // *****************************************************************
   bsx_pkg::bsx_byte_t      file_mem [0:127];
   bsx_pkg::bsx_byte_t      acc;
   logic [`BSX_IW_W-1:0]    instr;
   logic                    carry_flag;
   logic                    nibble_carry_flag;
   logic                    zero_flag;
   logic [1:0]              q_phase;
   logic [12:0]             program_counter;
   bsx_pkg::bsx_state_e     state;
   logic                    go;
   logic                    skip_seen;
   logic                    aw_held;
   logic                    w_held;
   logic [11:0]             aw_addr;
   logic [31:0]             w_data;
   logic [3:0]              w_strb;
   // *****************************************************************
   // Functions
   // *****************************************************************
   function automatic logic [9:0] sub_flags(input logic [7:0] a,
                                            input logic [7:0] w);
      logic [8:0] full;
      logic [4:0] low;
      full = {1'b0, a} - {1'b0, w};
      low  = {1'b0, a[3:0]} - {1'b0, w[3:0]};
      sub_flags = {~low[4], ~full[8], full[7:0]};
   endfunction : sub_flags
   function automatic logic is_file(input logic [11:0] a);
      is_file = (a[11:9] == `BSX_A_FILE_HI);
   endfunction : is_file
   // *****************************************************************
   // Decode
   // *****************************************************************
   logic [`BSX_F_W-1:0] f_addr;
   logic [2:0]          bsel;
   logic [7:0]          lit;
   logic [7:0]          f_val;
   logic                dec_bclr;
   logic                dec_bset;
   logic                dec_btst;
   logic                dec_lma;
   logic                dec_rma;
   logic [9:0]          sub_res;
   logic                exec_now;
   logic                cycle_end;
   assign f_addr   = instr[`BSX_F_HI:`BSX_F_LO];
   assign bsel     = instr[`BSX_BSEL_HI:`BSX_BSEL_LO];
   assign lit      = instr[`BSX_K_HI:`BSX_K_LO];
   assign f_val    = file_mem[f_addr];
   assign dec_bclr = instr[`BSX_OP_GRP_HI:`BSX_OP_GRP_LO] == `BSX_GRP_BIT
                  && instr[`BSX_BIT_OP_HI:`BSX_BIT_OP_LO] == `BSX_BIT_CLR;
   assign dec_bset = instr[`BSX_OP_GRP_HI:`BSX_OP_GRP_LO] == `BSX_GRP_BIT
                  && instr[`BSX_BIT_OP_HI:`BSX_BIT_OP_LO] == `BSX_BIT_SET;
   assign dec_btst = instr[`BSX_OP_GRP_HI:`BSX_OP_GRP_LO] == `BSX_GRP_BIT
                  && instr[`BSX_BIT_OP_HI:`BSX_BIT_OP_LO] == `BSX_BIT_TSTC;
   // Bit 8 is a don't-care for the literal form
   assign dec_lma  = instr[`BSX_LMA_HI:`BSX_LMA_LO] == `BSX_LMA_CODE;
   assign dec_rma  = instr[`BSX_RMA_HI:`BSX_RMA_LO] == `BSX_RMA_CODE;
   assign sub_res  = sub_flags(dec_lma ? lit : f_val, acc);
   assign cycle_end = (q_phase == `BSX_Q_LAST);
   assign exec_now = (state == bsx_pkg::BSX_EXEC) && cycle_end;

   // *****************************************************************
   // Instruction cycle: four oscillator periods
   // *****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn || state == bsx_pkg::BSX_IDLE) begin
         q_phase <= 2'h0;
      end else begin
         q_phase <= q_phase + 2'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= bsx_pkg::BSX_IDLE;
      end else begin
         unique case (state)
            bsx_pkg::BSX_IDLE: begin
               if (go) begin
                  state <= bsx_pkg::BSX_EXEC;
               end
            end
            bsx_pkg::BSX_EXEC: begin
               if (cycle_end) begin
                  if (dec_btst && !f_val[bsel]) begin
                     state <= bsx_pkg::BSX_NOP;
                  end else begin
                     state <= bsx_pkg::BSX_IDLE;
                  end
               end
            end
            bsx_pkg::BSX_NOP: begin
               if (cycle_end) begin
                  state <= bsx_pkg::BSX_IDLE;
               end
            end
            default: begin
               state <= bsx_pkg::BSX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         program_counter <= 13'h0000;
         skip_seen       <= 1'b0;
      end else if (exec_now) begin
         skip_seen <= dec_btst && !f_val[bsel];
         program_counter <= program_counter + ((dec_btst && !f_val[bsel])
                                               ? 13'h0002 : 13'h0001);
      end
   end

   // *****************************************************************
   // Execute: accumulator and flags
   // *****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc <= 8'h00;
      end else if (exec_now && (dec_lma ||
                   (dec_rma && instr[`BSX_D_BIT] == `BSX_D_ACC))) begin
         acc <= sub_res[7:0];
      end else if (aw_held && w_held && aw_addr == `BSX_A_ACC
                   && state == bsx_pkg::BSX_IDLE && w_strb[0]) begin
         acc <= w_data[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         carry_flag        <= 1'b0;
         nibble_carry_flag <= 1'b0;
         zero_flag         <= 1'b0;
      end else if (exec_now && (dec_lma || dec_rma)) begin
         carry_flag        <= sub_res[8];
         nibble_carry_flag <= sub_res[9];
         zero_flag         <= (sub_res[7:0] == 8'h00);
      end
   end

   // *****************************************************************
   // File registers
   // *****************************************************************
   always_ff @(posedge aclk) begin
      if (exec_now && dec_bclr) begin
         file_mem[f_addr][bsel] <= 1'b0;
      end else if (exec_now && dec_bset) begin
         file_mem[f_addr][bsel] <= 1'b1;
      end else if (exec_now && dec_rma && instr[`BSX_D_BIT]) begin
         file_mem[f_addr] <= sub_res[7:0];
      end else if (aw_held && w_held && is_file(aw_addr)
                   && state == bsx_pkg::BSX_IDLE && w_strb[0]) begin
         file_mem[aw_addr[8:2]] <= w_data[7:0];
      end
   end

   // *****************************************************************
   // AXI4-Lite write
   // *****************************************************************
   logic wr_fire;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_addr       <= 12'h000;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            aw_addr       <= {s_axi_awaddr[11:2], 2'h0};
            s_axi_awready <= 1'b0;
         end else if (wr_fire) begin
            aw_held       <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (wr_fire) begin
            w_held       <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `BSX_RESP_OK;
         go           <= 1'b0;
         instr        <= 14'h0000;
      end else begin
         go <= 1'b0;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `BSX_RESP_OK;
            // Writes land only while the core is idle
            if (state != bsx_pkg::BSX_IDLE) begin
               s_axi_bresp <= `BSX_RESP_ERR;
            end else if (aw_addr == `BSX_A_INSTR) begin
               instr <= w_data[`BSX_IW_W-1:0];
            end else if (aw_addr == `BSX_A_CTRL) begin
               go <= w_data[`BSX_CTRL_GO] && w_strb[0];
            end else if (aw_addr != `BSX_A_ACC && !is_file(aw_addr)) begin
               s_axi_bresp <= `BSX_RESP_ERR;
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // *****************************************************************
   // AXI4-Lite read
   // *****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `BSX_RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `BSX_RESP_OK;
         s_axi_rdata   <= 32'h0000_0000;
         if ({s_axi_araddr[11:2], 2'h0} == `BSX_A_CTRL) begin
            s_axi_rdata <= 32'h0000_0000;
         end else if ({s_axi_araddr[11:2], 2'h0} == `BSX_A_INSTR) begin
            s_axi_rdata <= {18'h0, instr};
         end else if ({s_axi_araddr[11:2], 2'h0} == `BSX_A_ACC) begin
            s_axi_rdata <= {24'h0, acc};
         end else if ({s_axi_araddr[11:2], 2'h0} == `BSX_A_STATUS) begin
            s_axi_rdata <= {27'h0, skip_seen, state != bsx_pkg::BSX_IDLE,
                            zero_flag, nibble_carry_flag, carry_flag};
         end else if ({s_axi_araddr[11:2], 2'h0} == `BSX_A_PROG_CNT) begin
            s_axi_rdata <= {19'h0, program_counter};
         end else if (is_file(s_axi_araddr)) begin
            s_axi_rdata <= {24'h0, file_mem[s_axi_araddr[8:2]]};
         end else begin
            s_axi_rresp <= `BSX_RESP_ERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // *****************************************************************
   // Assertions
   // *****************************************************************
   sequence s_exec_start;
      state == bsx_pkg::BSX_IDLE && go;
   endsequence
   property p_cycle_len;
      @(posedge aclk) disable iff (!aresetn) s_exec_start
         |=> (state == bsx_pkg::BSX_EXEC) [*4] ##1 state != bsx_pkg::BSX_EXEC;
   endproperty
   a_cycle_len: assert property (p_cycle_len)
      else $error("instruction cycle not four clocks");
   property p_skip_nop;
      @(posedge aclk) disable iff (!aresetn) exec_now && dec_btst
         && !f_val[bsel] |=> (state == bsx_pkg::BSX_NOP) [*4];
   endproperty
   a_skip_nop: assert property (p_skip_nop)
      else $error("skip did not insert a four-clock nop");
   property p_noskip;
      @(posedge aclk) disable iff (!aresetn) exec_now
         && !(dec_btst && !f_val[bsel]) |=> state == bsx_pkg::BSX_IDLE;
   endproperty
   a_noskip: assert property (p_noskip)
      else $error("single-cycle instruction took longer");
   property p_flags_hold;
      @(posedge aclk) disable iff (!aresetn)
      exec_now && (dec_bclr || dec_bset || dec_btst)
         |=> $stable({carry_flag, zero_flag, nibble_carry_flag});
   endproperty
   a_flags_hold: assert property (p_flags_hold)
      else $error("bit op changed a flag");
   property p_carry;
      @(posedge aclk) disable iff (!aresetn)
      exec_now && dec_lma |=> carry_flag == ($past(lit) >= $past(acc));
   endproperty
   a_carry: assert property (p_carry)
      else $error("carry wrong after literal subtract");
   property p_zero;
      @(posedge aclk) disable iff (!aresetn)
      exec_now && dec_lma |=> zero_flag == (acc == 8'h00);
   endproperty
   a_zero: assert property (p_zero)
      else $error("zero flag mismatch");
   property p_lma_acc;
      @(posedge aclk) disable iff (!aresetn)
      exec_now && dec_lma |=> acc == 8'($past(lit) - $past(acc));
   endproperty
   a_lma_acc: assert property (p_lma_acc)
      else $error("literal subtract result wrong");
   property p_dc;
      @(posedge aclk) disable iff (!aresetn) exec_now && dec_rma
         |=> nibble_carry_flag == ($past(f_val[3:0]) >= $past(acc[3:0]));
   endproperty
   a_dc: assert property (p_dc)
      else $error("nibble carry wrong");
   property p_rma_dest;
      @(posedge aclk) disable iff (!aresetn)
      exec_now && dec_rma && instr[`BSX_D_BIT] |=> $stable(acc);
   endproperty
   a_rma_dest: assert property (p_rma_dest)
      else $error("d=1 subtract touched accumulator");
endmodule : bsx_exec
`default_nettype wire

//--- hdl/bsx_map.svh
`ifndef BSX_MAP_SVH
`define BSX_MAP_SVH
// ********************************************************************
// Instruction fields
// ********************************************************************
`define BSX_IW_W        14
`define BSX_F_W         7
`define BSX_OP_GRP_HI   13
`define BSX_OP_GRP_LO   12
`define BSX_BIT_OP_HI   11
`define BSX_BIT_OP_LO   10
`define BSX_BSEL_HI     9
`define BSX_BSEL_LO     7
`define BSX_D_BIT       7
`define BSX_F_HI        6
`define BSX_F_LO        0
`define BSX_K_HI        7
`define BSX_K_LO        0
`define BSX_LMA_HI      13
`define BSX_LMA_LO      9
`define BSX_RMA_HI      13
`define BSX_RMA_LO      8
`define BSX_GRP_BIT     2'h1
`define BSX_BIT_CLR     2'h0
`define BSX_BIT_SET     2'h1
`define BSX_BIT_TSTC    2'h2
`define BSX_LMA_CODE    5'h1E
`define BSX_RMA_CODE    6'h02
`define BSX_D_ACC       1'h0
// ********************************************************************
// Register map (byte addresses)
// ********************************************************************
`define BSX_A_CTRL      12'h000
`define BSX_A_INSTR     12'h004
`define BSX_A_ACC       12'h008
`define BSX_A_STATUS    12'h00C
`define BSX_A_PROG_CNT  12'h010
`define BSX_A_FILE      12'h200
`define BSX_A_FILE_HI   3'h1
`define BSX_CTRL_GO     0
`define BSX_ST_C        0
`define BSX_ST_NC       1
`define BSX_ST_Z        2
`define BSX_ST_BUSY     3
`define BSX_ST_SKIP     4
`define BSX_Q_LAST      2'h3
`define BSX_RESP_OK     2'h0
`define BSX_RESP_ERR    2'h2
`endif

//--- hdl/bsx_pkg.sv
package bsx_pkg;
   typedef enum logic [2:0] {
      BSX_IDLE = 3'h1,
      BSX_EXEC = 3'h2,
      BSX_NOP  = 3'h4
   } bsx_state_e;
   typedef logic [7:0] bsx_byte_t;
endpackage : bsx_pkg

//--- verification/bit_and_subtract_instruction_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsx_map.svh"
module bit_and_subtract_instruction_exec_tb_top;
   logic        aclk, aresetn;
   logic [11:0] awaddr, araddr;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        ld_en;
   logic [12:0] ld_addr, fetch_addr;
   logic [13:0] ld_word, fetch_word;
   logic [2:0]  flg;
   logic        flg_ok;
   int          errors, n_tests;

   bsx_exec i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   bsx_prog_mem i_pmem (
      .aclk(aclk), .ld_en(ld_en), .ld_addr(ld_addr), .ld_word(ld_word),
      .fetch_addr(fetch_addr), .fetch_word(fetch_word));

   always #5 aclk = ~aclk;

   // ********************************************************************
   // Reporting
   // ********************************************************************
   task automatic conclude;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   task automatic chk_data(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_data

   task automatic chk_resp(input string nm, input logic [1:0] e, g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_resp

   // ********************************************************************
   // Bus master
   // ********************************************************************
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done  = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'hF;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd

   // Difference plus flags {zero, nibble carry, carry}
   function automatic logic [10:0] sub_res(input logic [7:0] a, w);
      logic [8:0] s;
      logic [4:0] n;
      s = {1'b0, a} - {1'b0, w};
      n = {1'b0, a[3:0]} - {1'b0, w[3:0]};
      return {s[7:0] == 8'h00, ~n[4], ~s[8], s[7:0]};
   endfunction : sub_res

   // ********************************************************************
   // One instruction: preload, fetch, run, compare
   // ********************************************************************
   task automatic run_op(input int op, input logic [6:0] f,
                         input logic [2:0] b, input logic d,
                         input logic [7:0] k, input logic x,
                         input logic [7:0] fv, input logic [7:0] av);
      logic [13:0] w;
      logic [31:0] v, pc0;
      logic [10:0] s;
      logic [7:0]  ea, ef;
      logic [2:0]  ef3;
      logic [1:0]  r;
      logic        sk;
      int          n;
      axi_wr(`BSX_A_FILE + {3'h0, f, 2'h0}, {24'h0, fv}, r);
      chk_resp("file write", `BSX_RESP_OK, r);
      axi_wr(`BSX_A_ACC, {24'h0, av}, r);
      axi_rd(`BSX_A_PROG_CNT, pc0, r);
      ea = av;
      ef = fv;
      ef3 = flg;
      sk = 1'b0;
      s = sub_res(k, av);
      case (op)
         0: begin
            w = {2'h1, 2'h0, b, f};
            ef[b] = 1'b0;
         end
         1: begin
            w = {2'h1, 2'h1, b, f};
            ef[b] = 1'b1;
         end
         2: begin
            w = {2'h1, 2'h2, b, f};
            sk = ~fv[b];
         end
         3: begin
            w = {5'h1E, x, k};
            ea = s[7:0];
            ef3 = s[10:8];
         end
         5: begin
            w = 14'h3FFF;
         end
         default: begin
            w = {6'h02, d, f};
            s = sub_res(fv, av);
            if (d) ef = s[7:0];
            else ea = s[7:0];
            ef3 = s[10:8];
         end
      endcase
      @(posedge aclk);
      ld_en   <= 1'b1;
      ld_addr <= pc0[12:0];
      ld_word <= w;
      @(posedge aclk);
      ld_en      <= 1'b0;
      fetch_addr <= pc0[12:0];
      @(posedge aclk);
      axi_wr(`BSX_A_INSTR, {18'h0, fetch_word}, r);
      axi_wr(`BSX_A_CTRL, 32'h0000_0001, r);
      n = 0;
      do begin
         axi_rd(`BSX_A_STATUS, v, r);
         n++;
      end while (v[3] !== 1'b0 && n < 50);
      chk_data("busy", 32'h0, v[3]);
      if (flg_ok || op >= 3) chk_data("flags", ef3, v[2:0]);
      chk_data("skip", sk, v[4]);
      axi_rd(`BSX_A_ACC, v, r);
      chk_data("acc", ea, v[7:0]);
      axi_rd(`BSX_A_FILE + {3'h0, f, 2'h0}, v, r);
      chk_data("file", ef, v[7:0]);
      axi_rd(`BSX_A_PROG_CNT, v, r);
      chk_data("count step", 13'h1 + sk, v[12:0] - pc0[12:0]);
      flg = ef3;
      if (op >= 3) flg_ok = 1'b1;
   endtask : run_op

   // ********************************************************************
   // Main sequence
   // ********************************************************************
   initial begin
      logic [31:0] v;
      logic [1:0]  r;
      aclk = 1'b0; aresetn = 1'b0;
      awaddr = 12'h000; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0;
      wvalid = 1'b0; bready = 1'b0; araddr = 12'h000; arvalid = 1'b0;
      rready = 1'b0; ld_en = 1'b0; ld_addr = 13'h0; ld_word = 14'h0;
      fetch_addr = 13'h0; flg = 3'h0; flg_ok = 1'b0;
      errors = 0; n_tests = 0;
      void'($urandom(35504));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      run_op(3, 7'h00, 3'h0, 1'b0, 8'h02, 1'b0, 8'h00, 8'h01);
      run_op(3, 7'h00, 3'h0, 1'b0, 8'h02, 1'b1, 8'h00, 8'h02);
      run_op(3, 7'h00, 3'h0, 1'b0, 8'h02, 1'b0, 8'h00, 8'h03);
      run_op(3, 7'h00, 3'h0, 1'b0, 8'h10, 1'b0, 8'h00, 8'h01);
      run_op(4, 7'h7F, 3'h0, 1'b1, 8'h00, 1'b0, 8'h03, 8'h02);
      run_op(4, 7'h05, 3'h0, 1'b0, 8'h00, 1'b0, 8'h01, 8'h02);
      run_op(0, 7'h7F, 3'h7, 1'b0, 8'h00, 1'b0, 8'hC7, 8'h00);
      run_op(1, 7'h7F, 3'h7, 1'b0, 8'h00, 1'b0, 8'h0A, 8'h00);
      run_op(2, 7'h11, 3'h1, 1'b0, 8'h00, 1'b0, 8'hFD, 8'h00);
      run_op(2, 7'h11, 3'h1, 1'b0, 8'h00, 1'b0, 8'h02, 8'h00);
      run_op(5, 7'h2A, 3'h0, 1'b0, 8'h00, 1'b0, 8'h5A, 8'h33);
      for (int i = 0; i < 60; i++) begin
         run_op($urandom % 5, 7'($urandom), 3'($urandom), 1'($urandom),
                8'($urandom), 1'($urandom), 8'($urandom), 8'($urandom));
      end
      axi_rd(12'h0FC, v, r);
      chk_resp("unmapped read", `BSX_RESP_ERR, r);
      chk_data("unmapped data", 32'h0, v);
      axi_wr(`BSX_A_STATUS, 32'h0000_0007, r);
      chk_resp("status write", `BSX_RESP_ERR, r);
      conclude();
   end

   // Watchdog: far beyond the expected few thousand cycles
   initial begin
      repeat (40000) @(posedge aclk);
      errors++;
      conclude();
   end
endmodule : bit_and_subtract_instruction_exec_tb_top
`default_nettype wire

//--- verification/bsx_prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************************************************
// Program memory model: stores and hands out instruction words
// ********************************************************************
module bsx_prog_mem (
   // Clock
   input  wire logic        aclk,
   // Load side
   input  wire logic        ld_en,
   input  wire logic [12:0] ld_addr,
   input  wire logic [13:0] ld_word,
   // Fetch side
   input  wire logic [12:0] fetch_addr,
   output logic      [13:0] fetch_word
);
   logic [13:0] mem [0:8191];

   always_ff @(posedge aclk) begin
      if (ld_en) begin
         mem[ld_addr] <= ld_word;
      end
   end

   assign fetch_word = mem[fetch_addr];
endmodule : bsx_prog_mem
`default_nettype wire
